// *** core/pressure_tuning_fallback_cutoff.sv ***
// Pressure-loop gain sets, stabilize stepping, integrator gating, travel/pressure
// fallback and target cutoffs of a valve positioner, behind a classic Wishbone slave.
// Assumes process inputs synchronous to clk and one clock domain.
//
// Local design decisions: register access over Wishbone and the address map.
`include "ptf_consts.svh"

module pressure_tuning_fallback_cutoff #(
  parameter int unsigned MS_CYCLES = `PTF_MS_NS / `PTF_CLK_NS
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Wishbone classic slave.
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  // Process measurements and targets.
  input wire ptf_pkg::process_in_t proc_in,
  // Control outputs.
  output ptf_pkg::gains_t pressure_gains,
  output logic active_loop_state,
  output logic drive_zero_power,
  output logic signed [15:0] travel_target,
  output logic signed [15:0] pressure_target,
  output logic signed [15:0] pressure_command,
  output logic signed [15:0] integrator_out
);

  localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

  ptf_pkg::state_t s_q;
  ptf_pkg::state_t s_d;
  ptf_pkg::gains_t base_gains;
  logic signed [9:0] minor_loop_feedback_sum;
  logic bus_req;
  logic wr;
  logic dev_over;
  logic trigger;
  logic recover_ok;
  logic sel_write;
  logic signed [31:0] iprod;
  logic signed [31:0] isum;
  logic signed [31:0] span;
  logic signed [31:0] frac;
  logic signed [31:0] pscaled;
  logic [31:0] status;

  function automatic logic signed [15:0] merge16(input logic signed [15:0] old, input logic [31:0] dat,
                                                 input logic [3:0] sel);
    merge16 = old;
    if (sel[0]) begin
      merge16[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      merge16[15:8] = dat[15:8];
    end
  endfunction

  // Predefined pressure gain sets, proportional and integral scaled by ten.
  function automatic ptf_pkg::gains_t set_gains(input logic [3:0] idx);
    unique case (idx)
      4'h0: set_gains = '{8'h05, 8'h03, 8'h23};
      4'h1: set_gains = '{8'h16, 8'h01, 8'h23};
      4'h2: set_gains = '{8'h18, 8'h01, 8'h23};
      4'h3: set_gains = '{8'h1C, 8'h01, 8'h23};
      4'h4: set_gains = '{8'h1F, 8'h01, 8'h23};
      4'h5: set_gains = '{8'h24, 8'h01, 8'h22};
      4'h6: set_gains = '{8'h2A, 8'h01, 8'h1F};
      4'h7: set_gains = '{8'h30, 8'h01, 8'h1B};
      4'h8: set_gains = '{8'h38, 8'h01, 8'h17};
      4'h9: set_gains = '{8'h42, 8'h01, 8'h12};
      4'hA: set_gains = '{8'h4E, 8'h01, 8'h0C};
      default: set_gains = '{8'h5A, 8'h01, 8'h0C};
    endcase
  endfunction

  // A cutoff at its disable value never fires, so no separate enable is needed.
  function automatic logic signed [15:0] cutoff(input logic signed [15:0] sp, input logic signed [15:0] tgt,
                                                input logic signed [15:0] hi, input logic signed [15:0] lo);
    if (hi != `PTF_CUT_OFF_HI && sp > hi) begin
      cutoff = `PTF_CUT_FORCE_HI;
    end else if (lo != `PTF_CUT_OFF_LO && sp < lo) begin
      cutoff = `PTF_CUT_FORCE_LO;
    end else begin
      cutoff = tgt;
    end
  endfunction

  function automatic logic signed [15:0] abs16(input logic signed [15:0] v);
    abs16 = (v < 0) ? -v : v;
  endfunction

  always_comb begin
    base_gains = (s_q.gain_set == `PTF_SET_X) ? s_q.expert : set_gains(s_q.gain_set);
    minor_loop_feedback_sum = $signed({2'b00, base_gains.minor_loop_feedback}) + 10'(s_q.trim);
    pressure_gains.prop = base_gains.prop;
    pressure_gains.integ = base_gains.integ;
    pressure_gains.minor_loop_feedback = minor_loop_feedback_sum < 0 ? 8'h00 : (minor_loop_feedback_sum[8] ? 8'hFF : minor_loop_feedback_sum[7:0]);
  end

  assign status = {27'h0000000, s_q.span_hi <= s_q.span_lo, s_q.prompt, s_q.stab, s_q.fallback, s_q.press_loop};

  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    bus_req = wb_cyc && wb_stb;
    // Writes land on the edge at which the master sees ack, as classic Wishbone demands.
    wr = bus_req && wb_we && s_q.ack;
    sel_write = wr && wb_adr == `PTF_OFF_CTRL && wb_sel[0];
    if (bus_req && !s_q.ack) begin
      s_d.ack = 1'b1;
      unique case (wb_adr)
        `PTF_OFF_CTRL: s_d.rdata = {26'h0000000, s_q.dev_en, s_q.zp_open, s_q.sel, s_q.mode};
        `PTF_OFF_SET: s_d.rdata = {28'h0000000, s_q.gain_set};
        `PTF_OFF_PROP: s_d.rdata = {24'h000000, pressure_gains.prop};
        `PTF_OFF_INTEG: s_d.rdata = {24'h000000, pressure_gains.integ};
        `PTF_OFF_MINOR_LOOP_FEEDBACK: s_d.rdata = {24'h000000, pressure_gains.minor_loop_feedback};
        `PTF_OFF_DZONE: s_d.rdata = {16'h0000, s_q.dzone};
        `PTF_OFF_IHI: s_d.rdata = {16'h0000, s_q.ihi};
        `PTF_OFF_ILO: s_d.rdata = {16'h0000, s_q.ilo};
        `PTF_OFF_SPAN_HI: s_d.rdata = {16'h0000, s_q.span_hi};
        `PTF_OFF_SPAN_LO: s_d.rdata = {16'h0000, s_q.span_lo};
        `PTF_OFF_DEV_THR: s_d.rdata = {16'h0000, s_q.dev_thr};
        `PTF_OFF_DEV_DLY: s_d.rdata = {16'h0000, s_q.dev_dly};
        `PTF_OFF_MIN_SUP: s_d.rdata = {16'h0000, s_q.min_sup};
        `PTF_OFF_TCUT_HI: s_d.rdata = {16'h0000, s_q.tcut_hi};
        `PTF_OFF_TCUT_LO: s_d.rdata = {16'h0000, s_q.tcut_lo};
        `PTF_OFF_PCUT_HI: s_d.rdata = {16'h0000, s_q.pcut_hi};
        `PTF_OFF_PCUT_LO: s_d.rdata = {16'h0000, s_q.pcut_lo};
        `PTF_OFF_STATUS: s_d.rdata = status;
        `PTF_OFF_IACC: s_d.rdata = {16'h0000, s_q.iacc};
        default: s_d.rdata = 32'h00000000;
      endcase
    end

    if (wr) begin
      unique case (wb_adr)
        `PTF_OFF_CTRL: begin
          if (wb_sel[0]) begin
            s_d.mode = ptf_pkg::block_mode_t'(wb_dat_w[`PTF_CTRL_MODE]);
            s_d.sel = ptf_pkg::control_type_t'(wb_dat_w[`PTF_CTRL_SEL]);
            s_d.zp_open = wb_dat_w[`PTF_CTRL_ZP_OPEN];
            s_d.dev_en = wb_dat_w[`PTF_CTRL_DEV_EN];
          end
        end
        `PTF_OFF_SET: begin
          if (wb_sel[0] && wb_dat_w[3:0] <= `PTF_SET_X) begin
            s_d.expert = base_gains;
            s_d.gain_set = wb_dat_w[3:0];
            s_d.trim = 8'sh00;
          end
        end
        `PTF_OFF_PROP, `PTF_OFF_INTEG, `PTF_OFF_MINOR_LOOP_FEEDBACK: begin
          if (wb_sel[0]) begin
            // Start from what is in force so the untouched gains do not jump.
            s_d.expert = pressure_gains;
            s_d.trim = 8'sh00;
            s_d.gain_set = `PTF_SET_X;
            if (wb_adr == `PTF_OFF_PROP) begin
              s_d.expert.prop = wb_dat_w[7:0];
            end else if (wb_adr == `PTF_OFF_INTEG) begin
              s_d.expert.integ = wb_dat_w[7:0];
            end else begin
              s_d.expert.minor_loop_feedback = wb_dat_w[7:0];
            end
          end
        end
        `PTF_OFF_DZONE: s_d.dzone = merge16(s_q.dzone, wb_dat_w, wb_sel);
        `PTF_OFF_IHI: s_d.ihi = merge16(s_q.ihi, wb_dat_w, wb_sel);
        `PTF_OFF_ILO: s_d.ilo = merge16(s_q.ilo, wb_dat_w, wb_sel);
        `PTF_OFF_SPAN_HI: s_d.span_hi = merge16(s_q.span_hi, wb_dat_w, wb_sel);
        `PTF_OFF_SPAN_LO: s_d.span_lo = merge16(s_q.span_lo, wb_dat_w, wb_sel);
        `PTF_OFF_DEV_THR: s_d.dev_thr = merge16(s_q.dev_thr, wb_dat_w, wb_sel);
        `PTF_OFF_DEV_DLY: s_d.dev_dly = merge16(s_q.dev_dly, wb_dat_w, wb_sel);
        `PTF_OFF_MIN_SUP: s_d.min_sup = merge16(s_q.min_sup, wb_dat_w, wb_sel);
        `PTF_OFF_TCUT_HI: s_d.tcut_hi = merge16(s_q.tcut_hi, wb_dat_w, wb_sel);
        `PTF_OFF_TCUT_LO: s_d.tcut_lo = merge16(s_q.tcut_lo, wb_dat_w, wb_sel);
        `PTF_OFF_PCUT_HI: s_d.pcut_hi = merge16(s_q.pcut_hi, wb_dat_w, wb_sel);
        `PTF_OFF_PCUT_LO: s_d.pcut_lo = merge16(s_q.pcut_lo, wb_dat_w, wb_sel);
        `PTF_OFF_STAB: begin
          if (wb_sel[0]) begin
            if (wb_dat_w[`PTF_STAB_ENTER]) begin
              s_d.stab = 1'b1;
            end
            if (s_q.stab) begin
              // Response stepping is meaningless from the expert set, so it is ignored there; damping trim still steps.
              if (wb_dat_w[`PTF_STAB_DEC_RESP] && s_q.gain_set > `PTF_SET_C && s_q.gain_set <= `PTF_SET_M) begin
                s_d.gain_set = s_q.gain_set - 4'h1;
                s_d.trim = 8'sh00;
              end else if (wb_dat_w[`PTF_STAB_INC_RESP] && s_q.gain_set < `PTF_SET_M) begin
                s_d.gain_set = s_q.gain_set + 4'h1;
                s_d.trim = 8'sh00;
              end else if (wb_dat_w[`PTF_STAB_INC_DAMP] && s_q.trim < `PTF_TRIM_MAX) begin
                s_d.trim = s_q.trim + `PTF_TRIM_STEP;
              end else if (wb_dat_w[`PTF_STAB_DEC_DAMP] && s_q.trim > -`PTF_TRIM_MAX) begin
                s_d.trim = s_q.trim - `PTF_TRIM_STEP;
              end
              if (wb_dat_w[`PTF_STAB_EXIT]) begin
                s_d.stab = 1'b0;
                s_d.prompt = 1'b1;
              end
            end
            if (s_q.prompt && (wb_dat_w[`PTF_STAB_YES] || wb_dat_w[`PTF_STAB_NO])) begin
              s_d.prompt = 1'b0;
              if (wb_dat_w[`PTF_STAB_YES]) begin
                s_d.mode = ptf_pkg::MODE_AUTO;
              end
            end
          end
        end
        default: ;
      endcase
    end

    // Deviation timer in milliseconds; supply below minimum blocks it.
    s_d.presc = (s_q.presc == MS_LAST) ? 16'h0000 : s_q.presc + 16'h0001;
    dev_over = s_q.dev_en && proc_in.deviation > s_q.dev_thr && proc_in.supply >= s_q.min_sup;
    if (!dev_over) begin
      s_d.dev_ms = 16'h0000;
    end else if (s_q.presc == MS_LAST && s_q.dev_ms != 16'hFFFF) begin
      s_d.dev_ms = s_q.dev_ms + 16'h0001;
    end
    // Alert enables never enter this decision.
    trigger = !proc_in.sensor_ok || (dev_over && s_q.dev_ms > s_q.dev_dly);
    recover_ok = proc_in.sensor_ok && !dev_over;
    if (s_q.sel == ptf_pkg::SEL_TRAVEL || s_q.sel == ptf_pkg::SEL_PRESSURE) begin
      s_d.fallback = 1'b0;
    end else if (trigger) begin
      s_d.fallback = 1'b1;
    end else if (s_q.sel == ptf_pkg::SEL_FB_AUTO && recover_ok) begin
      s_d.fallback = 1'b0;
    end
    // Manual recovery only ends through a selector write, handled below.
    if (sel_write && (s_d.sel == ptf_pkg::SEL_TRAVEL || s_d.sel == ptf_pkg::SEL_FB_AUTO)) begin
      s_d.fallback = 1'b0;
    end
    s_d.press_loop = s_d.sel == ptf_pkg::SEL_PRESSURE || s_d.fallback;

    // Pressure integrator.
    iprod = 32'(proc_in.press_error) * $signed({24'h000000, pressure_gains.integ});
    isum = 32'(s_q.iacc) + iprod / `PTF_GAIN_SCALE;
    if (s_q.mode == ptf_pkg::MODE_OOS) begin
      s_d.iacc = 16'sh0000;
    end else if (proc_in.integ_tick && s_q.press_loop && abs16(proc_in.press_error) > s_q.dzone) begin
      if (isum > 32'(s_q.ihi)) begin
        s_d.iacc = s_q.ihi;
      end else if (isum < 32'(s_q.ilo)) begin
        s_d.iacc = s_q.ilo;
      end else begin
        s_d.iacc = isum[15:0];
      end
    end

    // Cutoffs act on the pre-characterized setpoint.
    s_d.ttgt = cutoff(proc_in.setpoint, proc_in.travel_in, s_q.tcut_hi, s_q.tcut_lo);
    s_d.ptgt = cutoff(proc_in.setpoint, proc_in.press_in, s_q.pcut_hi, s_q.pcut_lo);

    // Span mapping; the target is limited to 0..100 percent before scaling.
    span = 32'(s_q.span_hi) - 32'(s_q.span_lo);
    frac = (s_q.ptgt < 0) ? 32'sh00000000 : ((32'(s_q.ptgt) > `PTF_FULL) ? `PTF_FULL : 32'(s_q.ptgt));
    pscaled = span * frac / `PTF_FULL;
    s_d.pcmd = s_q.zp_open ? 16'(32'(s_q.span_hi) - pscaled) : 16'(32'(s_q.span_lo) + pscaled);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.mode <= ptf_pkg::MODE_OOS;
      s_q.gain_set <= `PTF_RST_SET;
      s_q.dzone <= `PTF_RST_DZONE;
      s_q.ihi <= `PTF_RST_IHI;
      s_q.ilo <= `PTF_RST_ILO;
      s_q.span_hi <= `PTF_RST_SPAN_HI;
      s_q.span_lo <= `PTF_RST_SPAN_LO;
      s_q.dev_thr <= `PTF_RST_DEV_THR;
      s_q.dev_dly <= `PTF_RST_DEV_DLY;
      s_q.min_sup <= `PTF_RST_MIN_SUP;
      s_q.tcut_hi <= `PTF_CUT_OFF_HI;
      s_q.tcut_lo <= `PTF_CUT_OFF_LO;
      s_q.pcut_hi <= `PTF_CUT_OFF_HI;
      s_q.pcut_lo <= `PTF_CUT_OFF_LO;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_ack = s_q.ack;
  assign wb_dat_r = s_q.rdata;
  assign active_loop_state = s_q.press_loop;
  assign drive_zero_power = s_q.mode == ptf_pkg::MODE_OOS;
  assign travel_target = s_q.ttgt;
  assign pressure_target = s_q.ptgt;
  assign pressure_command = s_q.pcmd;
  assign integrator_out = s_q.iacc;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_oos_zero_power: assert property (s_q.mode == ptf_pkg::MODE_OOS
    |-> drive_zero_power ##1 integrator_out == 16'sh0000)
    else $error("out of service without zero-power drive");
  a_direct_gain_x: assert property (wr && wb_sel[0] && wb_adr == `PTF_OFF_PROP |=> s_q.gain_set == `PTF_SET_X
    && pressure_gains.prop == $past(wb_dat_w[7:0]))
    else $error("direct gain write did not select expert set");
  a_step_down: assert property (wr && wb_adr == `PTF_OFF_STAB && wb_sel[0] && s_q.stab
    && wb_dat_w[`PTF_STAB_DEC_RESP] && s_q.gain_set > `PTF_SET_C && s_q.gain_set <= `PTF_SET_M
    |=> s_q.gain_set == $past(s_q.gain_set) - 4'h1)
    else $error("decrease response did not step down");
  a_set_b_gains: assert property (s_q.gain_set == `PTF_SET_B && s_q.trim == 0
    |-> pressure_gains == ptf_pkg::gains_t'{8'h05, 8'h03, 8'h23})
    else $error("set B gains wrong");
  a_prompt_yes: assert property (wr && wb_adr == `PTF_OFF_STAB && wb_sel[0] && s_q.prompt
    && wb_dat_w[`PTF_STAB_YES] |=> s_q.mode == ptf_pkg::MODE_AUTO && !s_q.prompt)
    else $error("yes answer did not set automatic mode");
  a_dead_zone: assert property (s_q.mode != ptf_pkg::MODE_OOS && abs16(proc_in.press_error) <= s_q.dzone
    |=> integrator_out == $past(integrator_out))
    else $error("integrator moved inside dead zone");
  a_integ_clamp: assert property (proc_in.integ_tick && s_q.press_loop && s_q.ilo <= s_q.ihi
    && s_q.mode != ptf_pkg::MODE_OOS && s_q.iacc <= s_q.ihi && s_q.iacc >= s_q.ilo
    |=> integrator_out <= $past(s_q.ihi)
    && integrator_out >= $past(s_q.ilo))
    else $error("integrator left its clamp");
  a_sensor_fail: assert property ((s_q.sel == ptf_pkg::SEL_FB_AUTO || s_q.sel == ptf_pkg::SEL_FB_MANUAL)
    && !proc_in.sensor_ok && !sel_write |=> active_loop_state)
    else $error("sensor failure did not force pressure loop");
  a_manual_hold: assert property (s_q.sel == ptf_pkg::SEL_FB_MANUAL && s_q.fallback && !sel_write
    ##1 !sel_write |-> s_q.fallback [*2])
    else $error("manual recovery left fallback by itself");
  a_auto_recover: assert property (s_q.sel == ptf_pkg::SEL_FB_AUTO && s_q.fallback && recover_ok && !wr
    |=> !active_loop_state)
    else $error("auto recovery did not resume travel");
  a_supply_gate: assert property (proc_in.supply < s_q.min_sup |=> s_q.dev_ms == 16'h0000)
    else $error("deviation timer ran on low supply");
  a_travel_cut_hi: assert property (s_q.tcut_hi != `PTF_CUT_OFF_HI && proc_in.setpoint > s_q.tcut_hi
    && !wr |=> travel_target == `PTF_CUT_FORCE_HI)
    else $error("travel high cutoff not applied");
  a_press_cut_lo: assert property (s_q.pcut_lo != `PTF_CUT_OFF_LO && proc_in.setpoint < s_q.pcut_lo
    && s_q.pcut_hi == `PTF_CUT_OFF_HI && !wr |=> pressure_target == `PTF_CUT_FORCE_LO)
    else $error("pressure low cutoff not applied");

  c_fallback_entry: cover property (!s_q.press_loop ##1 s_q.press_loop && s_q.fallback);
  c_auto_recovery: cover property (s_q.fallback && s_q.sel == ptf_pkg::SEL_FB_AUTO ##1 !s_q.fallback);
  c_stabilize_exit: cover property (s_q.stab ##1 s_q.prompt ##[1:50] s_q.mode == ptf_pkg::MODE_AUTO);
  c_integ_clamped: cover property (s_q.press_loop && s_q.iacc == s_q.ihi);

endmodule

// *** core/ptf_consts.svh ***
// Named constants for the pressure tuning, fallback and cutoff block.
// Assumes percentages in tenths of a percent and gains scaled by ten, except minor-loop gain.
`ifndef PTF_CONSTS_SVH
`define PTF_CONSTS_SVH

// Clock and time base.
`define PTF_CLK_NS 32'h00000028
`define PTF_MS_NS 32'h000F4240

// Register byte offsets.
`define PTF_OFF_CTRL 8'h00
`define PTF_OFF_SET 8'h04
`define PTF_OFF_PROP 8'h08
`define PTF_OFF_INTEG 8'h0C
`define PTF_OFF_MINOR_LOOP_FEEDBACK 8'h10
`define PTF_OFF_DZONE 8'h14
`define PTF_OFF_IHI 8'h18
`define PTF_OFF_ILO 8'h1C
`define PTF_OFF_SPAN_HI 8'h20
`define PTF_OFF_SPAN_LO 8'h24
`define PTF_OFF_DEV_THR 8'h28
`define PTF_OFF_DEV_DLY 8'h2C
`define PTF_OFF_MIN_SUP 8'h30
`define PTF_OFF_TCUT_HI 8'h34
`define PTF_OFF_TCUT_LO 8'h38
`define PTF_OFF_PCUT_HI 8'h3C
`define PTF_OFF_PCUT_LO 8'h40
`define PTF_OFF_STAB 8'h44
`define PTF_OFF_STATUS 8'h48
`define PTF_OFF_IACC 8'h4C

// Control register fields.
`define PTF_CTRL_MODE 1:0
`define PTF_CTRL_SEL 3:2
`define PTF_CTRL_ZP_OPEN 4
`define PTF_CTRL_DEV_EN 5

// Stabilize command bits.
`define PTF_STAB_ENTER 0
`define PTF_STAB_DEC_RESP 1
`define PTF_STAB_INC_RESP 2
`define PTF_STAB_INC_DAMP 3
`define PTF_STAB_DEC_DAMP 4
`define PTF_STAB_EXIT 5
`define PTF_STAB_YES 6
`define PTF_STAB_NO 7

// Gain set ordinals.
`define PTF_SET_B 4'h0
`define PTF_SET_C 4'h1
`define PTF_SET_M 4'hB
`define PTF_SET_X 4'hC

// Cutoff forcing values and disable values.
`define PTF_CUT_FORCE_HI 16'sh04CE
`define PTF_CUT_FORCE_LO -16'sh00E6
`define PTF_CUT_OFF_HI 16'sh04E2
`define PTF_CUT_OFF_LO -16'sh00FA

// Scaling and limits.
`define PTF_FULL 32'sh000003E8
`define PTF_GAIN_SCALE 32'sh0000000A
`define PTF_TRIM_STEP 8'sh01
`define PTF_TRIM_MAX 8'sh14

// Reset values.
`define PTF_RST_SET 4'h1
`define PTF_RST_DZONE 16'sh0000
`define PTF_RST_IHI 16'sh03E8
`define PTF_RST_ILO -16'sh03E8
`define PTF_RST_SPAN_HI 16'sh03E8
`define PTF_RST_SPAN_LO 16'sh0000
`define PTF_RST_DEV_THR 16'sh0064
`define PTF_RST_DEV_DLY 16'h000A
`define PTF_RST_MIN_SUP 16'sh0000

`endif

// *** core/ptf_pkg.sv ***
// Types shared by the pressure tuning, fallback and cutoff block.
// Assumes the constants header defines all numeric values.
package ptf_pkg;

  typedef enum logic [1:0] {MODE_AUTO, MODE_MAN, MODE_OOS, MODE_LO} block_mode_t;
  typedef enum logic [1:0] {SEL_TRAVEL, SEL_PRESSURE, SEL_FB_AUTO, SEL_FB_MANUAL} control_type_t;

  typedef struct packed {
    logic [7:0] prop;
    logic [7:0] integ;
    logic [7:0] minor_loop_feedback;
  } gains_t;

  typedef struct packed {
    logic sensor_ok;
    logic [15:0] deviation;
    logic signed [15:0] supply;
    logic signed [15:0] press_error;
    logic integ_tick;
    logic signed [15:0] setpoint;
    logic signed [15:0] travel_in;
    logic signed [15:0] press_in;
  } process_in_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    block_mode_t mode;
    control_type_t sel;
    logic zp_open;
    logic dev_en;
    logic [3:0] gain_set;
    gains_t expert;
    logic signed [7:0] trim;
    logic signed [15:0] dzone;
    logic signed [15:0] ihi;
    logic signed [15:0] ilo;
    logic signed [15:0] span_hi;
    logic signed [15:0] span_lo;
    logic [15:0] dev_thr;
    logic [15:0] dev_dly;
    logic signed [15:0] min_sup;
    logic signed [15:0] tcut_hi;
    logic signed [15:0] tcut_lo;
    logic signed [15:0] pcut_hi;
    logic signed [15:0] pcut_lo;
    logic stab;
    logic prompt;
    logic fallback;
    logic press_loop;
    logic [15:0] presc;
    logic [15:0] dev_ms;
    logic signed [15:0] iacc;
    logic signed [15:0] ttgt;
    logic signed [15:0] ptgt;
    logic signed [15:0] pcmd;
  } state_t;

endpackage

// *** tb/valve_process_model.sv ***
// Behavioural travel sensor and pressure plant feeding the process inputs.
// Assumes the bench changes health and setpoint just after rising edges.
module valve_process_model (
  // Clock and stimulus.
  input wire logic clk,
  input wire logic healthy,
  input wire logic signed [15:0] sp,
  input wire logic [15:0] dev,
  // Process inputs of the block.
  output ptf_pkg::process_in_t pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] phase_q = 3'h0;
  always_ff @(posedge clk) begin
    phase_q <= phase_q + 3'h1;
  end
  // Supply is fixed, so the bench blocks deviation fallback by raising the minimum instead.
  assign pin = '{healthy, dev, 16'sh0200, 16'sh0010, phase_q == 3'h0, sp, sp, sp};
endmodule

// *** tb/pressure_tuning_fallback_cutoff_bench.sv ***
// Self-checking bench for the pressure tuning, fallback and cutoff block.
// Assumes the register map and reset values of the constants header.
`include "ptf_consts.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: %h vs %h", $time, a, e); end end
module pressure_tuning_fallback_cutoff_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ok = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [15:0] dev = 16'h0000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dw = 32'h0, dr, rv;
  logic ack, als, dzp;
  logic signed [15:0] sp = 16'sh0000, tt, pt, pc, io;
  ptf_pkg::process_in_t pin;
  ptf_pkg::gains_t g;
  int n_errors = 0, compares = 0;
  logic [7:0] prop_t [12] = '{8'h05, 8'h16, 8'h18, 8'h1C, 8'h1F, 8'h24, 8'h2A, 8'h30, 8'h38, 8'h42, 8'h4E, 8'h5A};
  logic [7:0] minor_loop_feedback_t [12] = '{8'h23, 8'h23, 8'h23, 8'h23, 8'h23, 8'h22, 8'h1F, 8'h1B, 8'h17, 8'h12, 8'h0C, 8'h0C};
  logic [7:0] goff [3] = '{`PTF_OFF_PROP, `PTF_OFF_INTEG, `PTF_OFF_MINOR_LOOP_FEEDBACK};
  valve_process_model plant (.clk(clk), .healthy(ok), .sp(sp), .dev(dev), .pin(pin));
  pressure_tuning_fallback_cutoff #(.MS_CYCLES(4)) uut (.clk(clk), .resetn(resetn), .wb_cyc(cyc),
    .wb_stb(stb), .wb_we(we), .wb_adr(adr), .wb_sel(sel), .wb_dat_w(dw), .wb_dat_r(dr), .wb_ack(ack),
    .proc_in(pin), .pressure_gains(g), .active_loop_state(als), .drive_zero_power(dzp),
    .travel_target(tt), .pressure_target(pt), .pressure_command(pc), .integrator_out(io));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic end_of_test();
    if (n_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // The request is held until ack is sampled, so a slow answer never tears a cycle.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, sel, dw} <= {2'b11, w, a, 4'h3, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      n_errors++;
      end_of_test();
    end
    rv = dr;
    {cyc, stb, we} <= 3'b000;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rv & m, e)
  endtask
  task automatic cut(input logic [7:0] a, input logic [31:0] l, input logic signed [15:0] s, input logic p,
    input logic signed [15:0] e);
    wr(a, l);
    sp <= s;
    tick(3);
    `CHK(p ? pt : tt, e)
  endtask
  initial begin
    tick(6);
    `CHK(dzp, 1'b1)
    resetn <= 1'b1;
    rd(`PTF_OFF_SET, 32'hF, 32'h1);
    rd(`PTF_OFF_ILO, 32'hFFFF, 32'hFC18);
    rd(8'h80, 32'hFFFFFFFF, 32'h0);
    for (int i = 0; i < 12; i++) begin
      wr(`PTF_OFF_SET, 32'(i));
      tick(1);
      `CHK(g, {prop_t[i], (i == 0) ? 8'h03 : 8'h01, minor_loop_feedback_t[i]})
    end
    wr(`PTF_OFF_SET, 32'hD);
    rd(`PTF_OFF_SET, 32'hF, 32'hB);
    foreach (goff[k]) begin
      wr(`PTF_OFF_SET, 32'h1);
      wr(goff[k], 32'h40);
      rd(`PTF_OFF_SET, 32'hF, 32'hC);
    end
    `CHK(g.minor_loop_feedback, 8'h40)
    wr(`PTF_OFF_SET, 32'hB);
    wr(`PTF_OFF_STAB, 32'h01);
    wr(`PTF_OFF_STAB, 32'h04);
    rd(`PTF_OFF_SET, 32'hF, 32'hB);
    wr(`PTF_OFF_STAB, 32'h02);
    rd(`PTF_OFF_SET, 32'hF, 32'hA);
    wr(`PTF_OFF_STAB, 32'h04);
    rd(`PTF_OFF_SET, 32'hF, 32'hB);
    wr(`PTF_OFF_STAB, 32'h08);
    tick(1);
    `CHK(g.minor_loop_feedback, 8'h0D)
    wr(`PTF_OFF_STAB, 32'h10);
    wr(`PTF_OFF_STAB, 32'h10);
    tick(1);
    `CHK(g.minor_loop_feedback, 8'h0B)
    wr(`PTF_OFF_STAB, 32'h20);
    rd(`PTF_OFF_STATUS, 32'h8, 32'h8);
    wr(`PTF_OFF_STAB, 32'h40);
    tick(1);
    `CHK(dzp, 1'b0)
    wr(`PTF_OFF_CTRL, 32'h08);
    ok <= 1'b0;
    tick(3);
    `CHK(als, 1'b1)
    ok <= 1'b1;
    tick(3);
    `CHK(als, 1'b0)
    wr(`PTF_OFF_CTRL, 32'h0C);
    ok <= 1'b0;
    tick(3);
    ok <= 1'b1;
    tick(3);
    `CHK(als, 1'b1)
    wr(`PTF_OFF_CTRL, 32'h00);
    tick(3);
    `CHK(als, 1'b0)
    wr(`PTF_OFF_CTRL, 32'h04);
    tick(3);
    `CHK(als, 1'b1)
    cut(`PTF_OFF_TCUT_HI, 32'h1F4, 16'sh0258, 1'b0, `PTF_CUT_FORCE_HI);
    cut(`PTF_OFF_TCUT_HI, 32'h4E2, 16'sh04D8, 1'b0, 16'sh04D8);
    cut(`PTF_OFF_TCUT_LO, 32'h5, 16'sh0000, 1'b0, `PTF_CUT_FORCE_LO);
    cut(`PTF_OFF_TCUT_LO, 32'hFF06, 16'shFF10, 1'b0, 16'shFF10);
    cut(`PTF_OFF_PCUT_HI, 32'h1F4, 16'sh0258, 1'b1, `PTF_CUT_FORCE_HI);
    cut(`PTF_OFF_PCUT_HI, 32'h4E2, 16'sh04D8, 1'b1, 16'sh04D8);
    cut(`PTF_OFF_PCUT_LO, 32'h5, 16'sh0000, 1'b1, `PTF_CUT_FORCE_LO);
    cut(`PTF_OFF_PCUT_LO, 32'hFF06, 16'shFF10, 1'b1, 16'shFF10);
    sp <= 16'sh00C8;
    tick(3);
    `CHK(pc, 16'sh00C8)
    wr(`PTF_OFF_CTRL, 32'h14);
    tick(3);
    `CHK(pc, 16'sh0320)
    wr(`PTF_OFF_IHI, 32'h3);
    tick(30);
    `CHK(io, 16'sh0003)
    wr(`PTF_OFF_DZONE, 32'h10);
    wr(`PTF_OFF_IHI, 32'h3E8);
    tick(30);
    `CHK(io, 16'sh0003)
    wr(`PTF_OFF_DZONE, 32'h0);
    wr(`PTF_OFF_IHI, 32'h5);
    tick(30);
    `CHK(io, 16'sh0005)
    wr(`PTF_OFF_CTRL, 32'h28);
    wr(`PTF_OFF_DEV_DLY, 32'h2);
    dev <= 16'h00C8;
    tick(4);
    `CHK(als, 1'b0)
    tick(20);
    `CHK(als, 1'b1)
    dev <= 16'h0000;
    tick(3);
    `CHK(als, 1'b0)
    wr(`PTF_OFF_MIN_SUP, 32'h300);
    dev <= 16'h00C8;
    tick(30);
    `CHK(als, 1'b0)
    end_of_test();
  end
endmodule
